//--- rtl/pvic_pkg.sv
`default_nettype none
package pvic_pkg;
    localparam int          PVIC_NSRC      = 24;
    localparam int          PVIC_NVEC      = 10;
    localparam logic [1:0]  PVIC_LVL_NONE  = 2'h0;
    localparam logic [1:0]  PVIC_LVL_LOW   = 2'h1;
    localparam logic [1:0]  PVIC_LVL_HIGH  = 2'h2;
    localparam logic [1:0]  PVIC_LVL_TOP   = 2'h3;
    localparam logic [15:0] PVIC_VEC_BASE  = 16'h0003;
    localparam logic [15:0] PVIC_VEC_STEP  = 16'h0008;
    localparam logic [15:0] PVIC_VEC_LAST  = 16'h004b;
    localparam logic [3:0]  PVIC_TOP_VECS  = 4'h2;
    localparam logic [23:0] PVIC_FLAGS_RST = 24'h000000;
    localparam logic [2:0]  PVIC_SVC_RST   = 3'h0;
    // source positions in the flag list
    localparam int PVIC_SRC_EXT0   = 0;
    localparam int PVIC_SRC_EXT1   = 1;
    localparam int PVIC_SRC_EXT2   = 2;
    localparam int PVIC_SRC_T0LO   = 3;
    localparam int PVIC_SRC_EXT4   = 4;
    localparam int PVIC_SRC_REMOTE = 5;
    localparam int PVIC_SRC_EXT3   = 6;
    localparam int PVIC_SRC_EXT5   = 7;
    localparam int PVIC_SRC_BTA    = 8;
    localparam int PVIC_SRC_BTB    = 9;
    localparam int PVIC_SRC_T0HI   = 10;
    localparam int PVIC_SRC_T1LO   = 11;
    localparam int PVIC_SRC_T1HI   = 12;
    localparam int PVIC_SRC_SSA    = 13;
    localparam int PVIC_SRC_ARX    = 14;
    localparam int PVIC_SRC_SPB    = 15;
    localparam int PVIC_SRC_ATX    = 16;
    localparam int PVIC_SRC_ADC    = 17;
    localparam int PVIC_SRC_T6     = 18;
    localparam int PVIC_SRC_T7     = 19;
    localparam int PVIC_SRC_PORT0  = 20;
    localparam int PVIC_SRC_T4     = 21;
    localparam int PVIC_SRC_T5     = 22;
    localparam int PVIC_SRC_PWM    = 23;
    // sources feeding each vector, vector 9 first
    localparam logic [9:0][23:0] PVIC_VEC_SRC = {
        24'hf00000, 24'h0e0000, 24'h018000, 24'h006000, 24'h001800,
        24'h000400, 24'h0003c0, 24'h00003c, 24'h000002, 24'h000001};

    typedef enum logic [1:0] {
        PVIC_IDLE = 2'b01,
        PVIC_REQ  = 2'b10
    } pvic_st_t;

    function automatic logic [15:0] pvic_addr(input logic [3:0] idx);
        pvic_addr = 16'(PVIC_VEC_BASE + PVIC_VEC_STEP * {12'h000, idx});
    endfunction

    function automatic logic [1:0] pvic_lvl(input logic       upper,
                                            input logic [3:0] idx);
        if (!upper)
            pvic_lvl = PVIC_LVL_LOW;
        else if (idx < PVIC_TOP_VECS)
            pvic_lvl = PVIC_LVL_TOP;
        else
            pvic_lvl = PVIC_LVL_HIGH;
    endfunction

    function automatic logic [1:0] pvic_cur(input logic [2:0] svc);
        if (svc[2])
            pvic_cur = PVIC_LVL_TOP;
        else if (svc[1])
            pvic_cur = PVIC_LVL_HIGH;
        else if (svc[0])
            pvic_cur = PVIC_LVL_LOW;
        else
            pvic_cur = PVIC_LVL_NONE;
    endfunction
endpackage
`default_nettype wire

//--- rtl/pvic_arb.sv
`timescale 1ns/1ps
`default_nettype none
module pvic_arb
    import pvic_pkg::*;
(
    input  wire logic [9:0] pend,
    input  wire logic [9:0] upper_sel,
    input  wire logic [1:0] cur_lvl,
    output logic            hit,
    output logic [3:0]      idx,
    output logic [1:0]      lvl
);
    logic [1:0] cand;
    // walk downward so that on equal level the smaller address wins last
    always_comb
    begin
        hit  = 1'b0;
        idx  = 4'h0;
        lvl  = PVIC_LVL_NONE;
        cand = PVIC_LVL_NONE;
        for (int v = PVIC_NVEC - 1; v >= 0; v--)
        begin
            cand = pvic_lvl(upper_sel[v], 4'(v));
            if (pend[v] && cand > cur_lvl && cand >= lvl) // [R02] [R03] [R04]
            begin
                hit = 1'b1;
                idx = 4'(v);
                lvl = cand;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/pvic_top.sv
// Contract
// [R01] three levels low, high, highest; a higher level nests into a lower.
// [R02] in service, requests at or below the current level wait.
// [R03] among waiting vectors the highest level wins.
// [R04] on equal level the smallest vector address wins.
// [R05] twenty-four sources fold onto ten vector addresses.
// [R06] ext two, ext four, timer 0 low, remote share 00013H, high/low.
// [R07] ext three, ext five, both base-timer events share 0001BH, high/low.
// [R08] sync serial a and async receive share 00033H, high/low.
// [R09] serial b and async transmit share 0003BH, high/low.
// [R10] port 0, timers 4, 5 and both pulse-width channels share 0004BH.
// [R11] a readable flag list shows which sources caused the branch.
// [R12] ext zero on lowest vector, ext one next; each highest or low.
// [R13] timer 0 high, timer 1 pair, converter with timers 6, 7: high/low.
`timescale 1ns/1ps
`default_nettype none
module pvic_top
    import pvic_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ext_irq_zero,
    input  wire logic        ext_irq_one,
    input  wire logic        ext_irq_two,
    input  wire logic        ext_irq_three,
    input  wire logic        ext_irq_four,
    input  wire logic        ext_irq_five,
    input  wire logic        timer_zero_low_event,
    input  wire logic        timer_zero_high_event,
    input  wire logic        timer_one_low_event,
    input  wire logic        timer_one_high_event,
    input  wire logic        remote_receiver_event,
    input  wire logic        base_timer_event_a,
    input  wire logic        base_timer_event_b,
    input  wire logic        sync_serial_port_a,
    input  wire logic        serial_port_b,
    input  wire logic        async_serial_port_rx,
    input  wire logic        async_serial_port_tx,
    input  wire logic        converter_event,
    input  wire logic        timer_four_event,
    input  wire logic        timer_five_event,
    input  wire logic        timer_six_event,
    input  wire logic        timer_seven_event,
    input  wire logic        port_zero_event,
    input  wire logic        pulse_width_channel_a,
    input  wire logic        pulse_width_channel_b,
    input  wire logic [9:0]  vec_upper_sel,
    input  wire logic [23:0] src_clear,
    input  wire logic        cpu_ack,
    input  wire logic        cpu_reti,
    output logic             irq_req,
    output logic [15:0]      irq_vec_addr,
    output logic [1:0]       irq_level,
    output logic [2:0]       in_service,
    output logic [23:0]      pending_flags,
    output logic [23:0]      source_flag_list
);
    typedef struct packed {
        pvic_st_t    st;
        logic        req;
        logic [3:0]  idx;
        logic [15:0] addr;
        logic [1:0]  lvl;
        logic [2:0]  svc;
        logic [23:0] flags;
        logic [23:0] list;
    } pvic_state_t;

    pvic_state_t s_r;
    pvic_state_t s_nxt;
    logic [23:0] ev;
    logic [9:0]  pend;
    logic [1:0]  cur_lvl;
    logic        win_hit;
    logic [3:0]  win_idx;
    logic [1:0]  win_lvl;

    // both pulse-width channels fold into one flag so the list stays 24 wide
    always_comb
    begin
        ev                  = 24'h000000;
        ev[PVIC_SRC_EXT0]   = ext_irq_zero;                           // [R12]
        ev[PVIC_SRC_EXT1]   = ext_irq_one;                            // [R12]
        ev[PVIC_SRC_EXT2]   = ext_irq_two;                            // [R06]
        ev[PVIC_SRC_T0LO]   = timer_zero_low_event;                   // [R06]
        ev[PVIC_SRC_EXT4]   = ext_irq_four;                           // [R06]
        ev[PVIC_SRC_REMOTE] = remote_receiver_event;                  // [R06]
        ev[PVIC_SRC_EXT3]   = ext_irq_three;                          // [R07]
        ev[PVIC_SRC_EXT5]   = ext_irq_five;                           // [R07]
        ev[PVIC_SRC_BTA]    = base_timer_event_a;                     // [R07]
        ev[PVIC_SRC_BTB]    = base_timer_event_b;                     // [R07]
        ev[PVIC_SRC_T0HI]   = timer_zero_high_event;                  // [R13]
        ev[PVIC_SRC_T1LO]   = timer_one_low_event;                    // [R13]
        ev[PVIC_SRC_T1HI]   = timer_one_high_event;                   // [R13]
        ev[PVIC_SRC_SSA]    = sync_serial_port_a;                     // [R08]
        ev[PVIC_SRC_ARX]    = async_serial_port_rx;                   // [R08]
        ev[PVIC_SRC_SPB]    = serial_port_b;                          // [R09]
        ev[PVIC_SRC_ATX]    = async_serial_port_tx;                   // [R09]
        ev[PVIC_SRC_ADC]    = converter_event;                        // [R13]
        ev[PVIC_SRC_T6]     = timer_six_event;                        // [R13]
        ev[PVIC_SRC_T7]     = timer_seven_event;                      // [R13]
        ev[PVIC_SRC_PORT0]  = port_zero_event;                        // [R10]
        ev[PVIC_SRC_T4]     = timer_four_event;                       // [R10]
        ev[PVIC_SRC_T5]     = timer_five_event;                       // [R10]
        ev[PVIC_SRC_PWM]    = pulse_width_channel_a
                            | pulse_width_channel_b;                  // [R10]
    end

    always_comb
    begin
        for (int v = 0; v < PVIC_NVEC; v++)
            pend[v] = |(s_r.flags & PVIC_VEC_SRC[v]);                 // [R05]
    end

    assign cur_lvl = pvic_cur(s_r.svc);                               // [R01]

    pvic_arb pvic_arb_i (
        .pend      (pend),
        .upper_sel (vec_upper_sel),
        .cur_lvl   (cur_lvl),
        .hit       (win_hit),
        .idx       (win_idx),
        .lvl       (win_lvl)
    );

    always_comb
    begin
        s_nxt = s_r;
        // set beats clear so an event in the clearing cycle survives
        s_nxt.flags = (s_r.flags & ~src_clear) | ev;                  // [R05]
        // return retires only the innermost level in service
        if (cpu_reti)
        begin
            if (s_r.svc[2])
                s_nxt.svc[2] = 1'b0;
            else if (s_r.svc[1])
                s_nxt.svc[1] = 1'b0;
            else
                s_nxt.svc[0] = 1'b0;
        end
        unique case (s_r.st)
            PVIC_IDLE:
            begin
                if (win_hit && !cpu_reti)
                begin
                    s_nxt.st   = PVIC_REQ;
                    s_nxt.req  = 1'b1;
                    s_nxt.idx  = win_idx;                             // [R04]
                    s_nxt.addr = pvic_addr(win_idx);                  // [R05]
                    s_nxt.lvl  = win_lvl;                             // [R03]
                end
            end
            PVIC_REQ:
            begin
                if (cpu_ack)
                begin
                    // cpu takes the vector it saw; flags stay for software
                    s_nxt.st   = PVIC_IDLE;
                    s_nxt.req  = 1'b0;
                    s_nxt.svc[s_r.lvl - 2'h1] = 1'b1;                 // [R01]
                    s_nxt.list = s_r.flags & PVIC_VEC_SRC[s_r.idx];   // [R11]
                end
                else if (!win_hit)
                begin
                    // source cleared before the cpu answered: withdraw
                    s_nxt.st  = PVIC_IDLE;
                    s_nxt.req = 1'b0;
                end
                else
                begin
                    // a better request may overtake one not yet taken
                    s_nxt.idx  = win_idx;                             // [R03]
                    s_nxt.addr = pvic_addr(win_idx);
                    s_nxt.lvl  = win_lvl;                             // [R02]
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r.st    <= PVIC_IDLE;
            s_r.req   <= 1'b0;
            s_r.idx   <= 4'h0;
            s_r.addr  <= PVIC_VEC_BASE;
            s_r.lvl   <= PVIC_LVL_NONE;
            s_r.svc   <= PVIC_SVC_RST;
            s_r.flags <= PVIC_FLAGS_RST;
            s_r.list  <= PVIC_FLAGS_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign irq_req          = s_r.req;
    assign irq_vec_addr     = s_r.addr;
    assign irq_level        = s_r.lvl;
    assign in_service       = s_r.svc;
    assign pending_flags    = s_r.flags;
    assign source_flag_list = s_r.list;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_top_idle;
        s_r.svc == 3'h0 && !s_r.req;
    endsequence

    sequence s_top_raised;
        irq_req && irq_level == PVIC_LVL_TOP && irq_vec_addr == 16'h0003;
    endsequence

    a_req_above_svc: assert property (                               // [R02]
        irq_req |-> irq_level > pvic_cur(in_service))
        else $error("request not above level in service");

    a_ack_nests_lvl: assert property (                               // [R01]
        irq_req && cpu_ack && !cpu_reti
        |=> in_service[$past(irq_level) - 2'h1])
        else $error("taken level not marked in service");

    a_vec_in_table: assert property (                                // [R05]
        irq_req |-> irq_vec_addr <= PVIC_VEC_LAST
                    && irq_vec_addr[2:0] == 3'h3)
        else $error("vector address outside table");

    a_ext0_top_vec: assert property (                                // [R12]
        s_top_idle ##0 (ext_irq_zero && vec_upper_sel[0] && !cpu_reti
                        && !src_clear[PVIC_SRC_EXT0])
        |=> ##1 s_top_raised)
        else $error("ext zero not raised at highest level");

    a_ext2_latched: assert property (                                // [R06]
        ext_irq_two |=> pending_flags[PVIC_SRC_EXT2])
        else $error("ext two event lost");

    a_ext5_latched: assert property (                                // [R07]
        ext_irq_five |=> pending_flags[PVIC_SRC_EXT5])
        else $error("ext five event lost");

    a_arx_latched: assert property (                                 // [R08]
        async_serial_port_rx |=> pending_flags[PVIC_SRC_ARX])
        else $error("async receive event lost");

    a_atx_latched: assert property (                                 // [R09]
        async_serial_port_tx |=> pending_flags[PVIC_SRC_ATX])
        else $error("async transmit event lost");

    a_pwmb_latched: assert property (                                // [R10]
        pulse_width_channel_b |=> pending_flags[PVIC_SRC_PWM])
        else $error("pulse-width event lost");

    a_list_in_vec: assert property (                                 // [R11]
        irq_req && cpu_ack |=> source_flag_list != 24'h000000
            && (source_flag_list & ~PVIC_VEC_SRC[$past(s_r.idx)]) == 24'h0)
        else $error("flag list names a foreign source");

    a_h_beats_low: assert property (                                 // [R03]
        irq_req && !cpu_ack && win_hit && win_lvl > irq_level
        |=> irq_level == $past(win_lvl))
        else $error("higher level not preferred");

    // independent scan: nothing pending below the winner at its own level
    logic tie_lower;
    always_comb
    begin
        tie_lower = 1'b0;
        for (int v = 0; v < PVIC_NVEC; v++)
        begin
            if (pend[v] && 4'(v) < win_idx
                && pvic_lvl(vec_upper_sel[v], 4'(v)) == win_lvl)
                tie_lower = 1'b1;
        end
    end

    a_tie_low_addr: assert property (                                // [R04]
        win_hit |-> !tie_lower)
        else $error("equal level not to smallest address");

    a_t0hi_vec: assert property (                                    // [R13]
        irq_req && cpu_ack && irq_vec_addr == 16'h0023
        |=> source_flag_list[PVIC_SRC_T0HI])
        else $error("timer 0 high vector without its flag");
endmodule
`default_nettype wire

//--- tb/pvic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pvic_cpu_model
    import pvic_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vec_addr,
    input  wire logic        ack_en,
    input  wire logic [3:0]  ack_dly,
    input  wire logic        reti_cmd,
    output logic             cpu_ack,
    output logic             cpu_reti,
    output logic [15:0]      taken_addr
);
    logic [3:0] wait_r;
    // ack after ack_dly cycles of a standing request, one pulse per take
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_ack <= 1'b0;
            wait_r  <= 4'h0;
        end
        else if (cpu_ack || !irq_req || !ack_en)
        begin
            cpu_ack <= 1'b0;
            wait_r  <= 4'h0;
        end
        else if (wait_r >= ack_dly)
            cpu_ack <= 1'b1;
        else
            wait_r <= wait_r + 4'h1;
    end
    always @(posedge core_clk)
    begin
        if (cpu_ack && irq_req)
            taken_addr <= irq_vec_addr;
    end
    assign cpu_reti = reti_cmd && resetn;
endmodule
`default_nettype wire

//--- tb/pvic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pvic_tb_top
    import pvic_pkg::*;
;
    logic        core_clk, resetn, ack_en, reti_cmd;
    logic        cpu_ack, cpu_reti, irq_req;
    logic [24:0] ev;
    logic [9:0]  sel;
    logic [23:0] clr, pend, list;
    logic [15:0] addr, taken;
    logic [3:0]  ack_dly;
    logic [1:0]  lvl;
    logic [2:0]  insvc;
    int          error_cnt, n_tests;

    pvic_top pvic_top_i (
        .core_clk(core_clk), .resetn(resetn),
        .ext_irq_zero(ev[0]), .ext_irq_one(ev[1]),
        .ext_irq_two(ev[2]), .timer_zero_low_event(ev[3]),
        .ext_irq_four(ev[4]), .remote_receiver_event(ev[5]),
        .ext_irq_three(ev[6]), .ext_irq_five(ev[7]),
        .base_timer_event_a(ev[8]), .base_timer_event_b(ev[9]),
        .timer_zero_high_event(ev[10]), .timer_one_low_event(ev[11]),
        .timer_one_high_event(ev[12]), .sync_serial_port_a(ev[13]),
        .async_serial_port_rx(ev[14]), .serial_port_b(ev[15]),
        .async_serial_port_tx(ev[16]), .converter_event(ev[17]),
        .timer_six_event(ev[18]), .timer_seven_event(ev[19]),
        .port_zero_event(ev[20]), .timer_four_event(ev[21]),
        .timer_five_event(ev[22]), .pulse_width_channel_a(ev[23]),
        .pulse_width_channel_b(ev[24]),
        .vec_upper_sel(sel), .src_clear(clr),
        .cpu_ack(cpu_ack), .cpu_reti(cpu_reti),
        .irq_req(irq_req), .irq_vec_addr(addr), .irq_level(lvl),
        .in_service(insvc), .pending_flags(pend),
        .source_flag_list(list));

    pvic_cpu_model pvic_cpu_model_i (
        .core_clk(core_clk), .resetn(resetn), .irq_req(irq_req),
        .irq_vec_addr(addr), .ack_en(ack_en), .ack_dly(ack_dly),
        .reti_cmd(reti_cmd), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti),
        .taken_addr(taken));

    always #5 core_clk = ~core_clk;

    task automatic check(input logic [23:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t %s %h/%h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_req(input logic want);
        int i;
        i = 0;
        while (irq_req !== want && i < 20)
        begin
            @(negedge core_clk);
            i++;
        end
        if (irq_req !== want)
        begin
            error_cnt++;
            $display("BAD t=%0t request wait ran out", $time);
            finish_test();
        end
    endtask

    task automatic fire(input logic [24:0] m);
        @(negedge core_clk);
        ev = m;
        @(negedge core_clk);
        ev = '0;
    endtask

    // returns one cycle after the flags drop, when the request has fallen
    task automatic clear(input logic [23:0] m);
        @(negedge core_clk);
        clr = m;
        @(negedge core_clk);
        clr = '0;
        @(negedge core_clk);
    endtask

    task automatic retire;
        @(negedge core_clk);
        reti_cmd = 1'b1;
        @(negedge core_clk);
        reti_cmd = 1'b0;
    endtask

    task automatic test_reset;
        check({2'h0, irq_req, lvl, insvc, addr}, 24'h000003, "reset");
        check(pend, 24'h000000, "reset flags");
        check(list, 24'h000000, "reset list");
        $display("reset test done");
    endtask

    task automatic test_map;
        int vmap[25] = '{0,1,2,2,2,2,3,3,3,3,4,5,5,6,6,7,7,8,8,8,9,9,9,9,9};
        logic [23:0] f;
        sel = 10'h000;
        ack_en = 1'b0;
        for (int i = 0; i < 25; i++)
        begin
            f = (i == 24) ? 24'h800000 : 24'h000001 << i;
            fire(25'h0000001 << i);
            check(pend, f, "flag");
            @(negedge core_clk);
            check({7'h00, irq_req, addr},
                  {8'h01, 16'(16'h0003 + 16'h0008 * vmap[i])},
                  "vector");
            check({22'h0, lvl}, 24'h000001, "low level");
            clear(f);
            check({23'h0, irq_req}, 24'h000000, "withdraw");
        end
        $display("map test done");
    endtask

    task automatic prio(input logic [9:0] s, input logic [24:0] m,
                        input logic [15:0] a, input logic [1:0] l);
        sel = s;
        fire(m);
        @(negedge core_clk);
        check({6'h0, lvl, addr}, {6'h0, l, a}, "winner");
        clear(24'hffffff);
    endtask

    task automatic test_prio;
        ack_en = 1'b0;
        prio(10'h200, 25'h0100004, 16'h004b, 2'h2);
        prio(10'h000, 25'h0002040, 16'h001b, 2'h1);
        prio(10'h3ff, 25'h1000003, 16'h0003, 2'h3);
        prio(10'h3ff, 25'h0000402, 16'h000b, 2'h3);
        $display("priority test done");
    endtask

    task automatic test_nest;
        sel = 10'h000;
        ack_dly = 4'h3;
        ack_en = 1'b1;
        fire(25'h0001800);
        wait_req(1'b1);
        wait_req(1'b0);
        check(list, 24'h001800, "list low");
        check({21'h0, insvc}, 24'h000001, "low svc");
        check({8'h0, taken}, 24'h00002b, "taken low");
        fire(25'h0000001);
        repeat (6)
        begin
            @(negedge core_clk);
            check({23'h0, irq_req}, 24'h000000, "refused");
        end
        sel = 10'h010;
        ack_dly = 4'h0;
        fire(25'h0000400);
        wait_req(1'b1);
        wait_req(1'b0);
        check({21'h0, insvc}, 24'h000003, "nested");
        check(list, 24'h000400, "list high");
        check({8'h0, taken}, 24'h000023, "taken high");
        clear(24'h001c00);
        ack_en = 1'b0;
        retire();
        check({21'h0, insvc}, 24'h000001, "reti one");
        retire();
        wait_req(1'b1);
        check({6'h0, lvl, addr}, 24'h010003, "resumed");
        clear(24'h000001);
        check({21'h0, insvc}, 24'h000000, "idle");
        $display("nesting test done");
    endtask

    // reset in mid-run with a request standing must bring everything back
    task automatic test_rst_mid;
        sel = 10'h000;
        fire(25'h0000004);
        wait_req(1'b1);
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        test_reset();
        @(negedge core_clk);
        check({23'h0, irq_req}, 24'h000000, "quiet after reset");
        $display("mid reset test done");
    endtask

    initial
    begin
        core_clk = 1'b0;
        resetn = 1'b0;
        ev = '0;
        sel = '0;
        clr = '0;
        ack_en = 1'b0;
        ack_dly = 4'h0;
        reti_cmd = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        test_reset();
        test_map();
        test_prio();
        test_nest();
        test_rst_mid();
        finish_test();
    end
endmodule
`default_nettype wire
